// ==== ssf_pkg.sv ====
/*
 * Shared constants, carrier types and decode helpers for the serial
 * port status flag block. Assumes a 32-bit AHB-Lite register bus and
 * a serial port engine on the same clock as the block.
 */
package ssf_pkg;

	// ----------------------------------------------------------------
	// Bus and register map
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned OFS_W  = 8;
	localparam logic [OFS_W-1:0] OFS_STATUS   = 8'h00;
	localparam logic [OFS_W-1:0] OFS_RESTART  = 8'h04;
	localparam logic [OFS_W-1:0] OFS_ERRCODE  = 8'h08;
	localparam logic [OFS_W-1:0] OFS_SETTINGS = 8'h0C;
	localparam logic [OFS_W-1:0] OFS_CTRL     = 8'h10;
	localparam logic [OFS_W-1:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [OFS_W-1:0] OFS_IRQ_CLR  = 8'h18;
	localparam logic [OFS_W-1:0] OFS_IRQ_EN   = 8'h1C;
	localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;
	localparam int unsigned      HTRANS_ACT_BIT = 1;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned UNIT_N        = 8;
	localparam int unsigned CODE_W        = 8;
	localparam int unsigned MODE_W        = 4;
	localparam int unsigned IRQ_W         = 4;
	localparam int unsigned STAT_ERR_BIT  = 0;
	localparam int unsigned STAT_ACT_LSB  = 8;
	localparam int unsigned FLAG_BIT      = 0;
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_AUTO_BIT = 4;
	localparam int unsigned CTRL_CLR_BIT  = 5;
	localparam int unsigned CTRL_W        = 6;
	localparam int unsigned CODE_PAR_BIT  = 2;
	localparam int unsigned CODE_FRM_BIT  = 3;
	localparam int unsigned CODE_OVR_BIT  = 4;
	localparam int unsigned CODE_TMO_BIT  = 5;
	localparam int unsigned IRQ_COMM_BIT  = 0;
	localparam int unsigned IRQ_CODE_BIT  = 1;
	localparam int unsigned IRQ_SETD_BIT  = 2;
	localparam int unsigned IRQ_RSTD_BIT  = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
	localparam logic [UNIT_N-1:0] ACT_RST  = 8'h00;
	localparam logic [IRQ_W-1:0]  IRQ_RST  = 4'h0;
	localparam logic [DATA_W-1:0] RD_ZERO  = 32'h00000000;

	// ----------------------------------------------------------------
	// Operating mode codes
	// ----------------------------------------------------------------
	localparam logic [MODE_W-1:0] MODE_PERIPH_BUS = 4'h1;
	localparam logic [MODE_W-1:0] MODE_OTL_1TO1   = 4'h2;
	localparam logic [MODE_W-1:0] MODE_OTL_1TON   = 4'h3;
	localparam logic [MODE_W-1:0] MODE_LINK_POLLD = 4'h7;
	localparam logic [MODE_W-1:0] MODE_LINK_POLLG = 4'h8;

	// ----------------------------------------------------------------
	// Carriers and states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic timeout;
		logic overrun;
		logic framing;
		logic parity;
	} ssf_err_ev_type;

	typedef struct packed {
		ssf_err_ev_type    err;
		logic [UNIT_N-1:0] unit_active;
		logic              setup_instr;
		logic              settings_done;
		logic              restart_done;
	} ssf_port_in_type;

	typedef struct packed {
		logic restart;
		logic settings_busy;
	} ssf_port_out_type;

	typedef enum logic [1:0] {
		RS_IDLE = 2'b01,
		RS_WAIT = 2'b10
	} ssf_rs_state_type;

	// ----------------------------------------------------------------
	// Mode decode helpers
	// ----------------------------------------------------------------
	function automatic logic f_is_link(input logic [MODE_W-1:0] m);
		return (m == MODE_LINK_POLLD) || (m == MODE_LINK_POLLG);
	endfunction

	function automatic logic f_is_otl(input logic [MODE_W-1:0] m);
		return (m == MODE_OTL_1TO1) || (m == MODE_OTL_1TON);
	endfunction

	function automatic logic f_flag_ok(input logic [MODE_W-1:0] m);
		return !(m == MODE_PERIPH_BUS || f_is_otl(m) || f_is_link(m));
	endfunction

	function automatic logic f_code_ok(input logic [MODE_W-1:0] m);
		return !(m == MODE_PERIPH_BUS || m == MODE_OTL_1TON || f_is_link(m));
	endfunction

endpackage

// ==== ssf_ahb_port.sv ====
/*
 * AHB-Lite slave front end: captures the address phase and presents a
 * write strobe in the data phase. Assumes single word transfers and
 * that the block is the only slave, so hready follows hreadyout.
 */
`timescale 1ns/1ps
module ssf_ahb_port
	import ssf_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	input  wire logic                 ce_i,
	input  wire logic                 hsel_i,
	input  wire logic [ssf_pkg::ADDR_W-1:0] haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic                 hready_i,
	output logic                      hreadyout_o,
	output logic                      rd_stb_o,
	output logic                      wr_stb_o,
	output logic [ssf_pkg::OFS_W-1:0] wr_ofs_o
);
	logic                 wr_pend_q;
	logic                 wr_pend_d;
	logic [OFS_W-1:0]     wr_ofs_q;
	logic [OFS_W-1:0]     wr_ofs_d;
	logic                 take;

	// ----------------------------------------------------------------
	// Address phase capture
	// ----------------------------------------------------------------
	// Stalling on ce low keeps the master holding its phase, nothing lost
	always_comb begin
		hreadyout_o = ce_i;
		take        = hsel_i && htrans_i[HTRANS_ACT_BIT] && hready_i && ce_i;
		rd_stb_o    = take && !hwrite_i;
		wr_stb_o    = wr_pend_q && ce_i;
		wr_ofs_o    = wr_ofs_q;
		wr_pend_d   = wr_pend_q;
		wr_ofs_d    = wr_ofs_q;
		if (hready_i && ce_i) begin
			wr_pend_d = take && hwrite_i;
			wr_ofs_d  = haddr_i[OFS_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_pend_q <= 1'b0;
			wr_ofs_q  <= '0;
		end else if (ce_i) begin
			wr_pend_q <= wr_pend_d;
			wr_ofs_q  <= wr_ofs_d;
		end
	end

endmodule

// ==== ssf_top.sv ====
/*
 * Serial port status and control flags: communications error flag,
 * per-unit activity bits, restart request, error code field and
 * settings-changed flag, with an AHB-Lite register file and one
 * interrupt. Assumes the serial port engine runs on clk_i and gives
 * one-cycle event pulses and level activity bits.
 */
// Notes on behaviour
// - A detected communications error sets the error flag; zero means normal.
// - A port restart clears the error flag.
// - The error flag is frozen in peripheral bus, terminal link and link modes.
// - Every flag of the block is zero after reset.
// - Eight activity bits follow units 0 to 7 while in terminal or link mode.
// - Writing 1 to the restart bit restarts the port unless in peripheral bus mode.
// - The restart bit may clear itself when restart processing ends.
// - The error field holds parity, framing, overrun and timeout at bits 2 to 5.
// - A restart may clear the error field.
// - The error field is frozen in peripheral bus, 1:N terminal and link modes.
// - The settings flag stays high while conditions change, then returns low.
// - The setup change instruction sets the settings flag.
`timescale 1ns/1ps
module ssf_top
	import ssf_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      reset_i,
	input  wire logic                      ce_i,
	input  wire logic                      hsel_i,
	input  wire logic [ssf_pkg::ADDR_W-1:0] haddr_i,
	input  wire logic [1:0]                htrans_i,
	input  wire logic                      hwrite_i,
	input  wire logic [2:0]                hsize_i,
	input  wire logic [ssf_pkg::DATA_W-1:0] hwdata_i,
	input  wire logic                      hready_i,
	output logic                           hreadyout_o,
	output logic                           hresp_o,
	output logic [ssf_pkg::DATA_W-1:0]     hrdata_o,
	input  wire ssf_pkg::ssf_port_in_type  port_i,
	output ssf_pkg::ssf_port_out_type      port_o,
	output logic [ssf_pkg::MODE_W-1:0]     mode_o,
	output logic                           irq_o
);
	logic                 rd_stb;
	logic                 wr_stb;
	logic [OFS_W-1:0]     wr_ofs;
	logic [OFS_W-1:0]     rd_ofs;
	logic                 comm_err_q, comm_err_d;
	logic [UNIT_N-1:0]    act_q, act_d;
	logic                 restart_q, restart_d;
	logic                 req_q, req_d;
	logic [CODE_W-1:0]    code_q, code_d;
	logic                 settings_q, settings_d;
	logic [CTRL_W-1:0]    ctrl_q, ctrl_d;
	logic [IRQ_W-1:0]     irq_stat_q, irq_stat_d;
	logic [IRQ_W-1:0]     irq_en_q, irq_en_d;
	logic [DATA_W-1:0]    hrdata_q, hrdata_d;
	ssf_rs_state_type     rs_q, rs_d;
	logic [MODE_W-1:0]    mode;
	logic                 go;
	logic                 rs_done;
	logic                 comm_ev;
	logic [CODE_W-1:0]    code_ev;
	logic                 flag_ok;
	logic                 code_ok;
	logic [IRQ_W-1:0]     irq_ev;

	// Hsize is not decoded: only whole words are carried
	ssf_ahb_port u_port (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.ce_i        (ce_i),
		.hsel_i      (hsel_i),
		.haddr_i     (haddr_i),
		.htrans_i    (htrans_i),
		.hwrite_i    (hwrite_i),
		.hready_i    (hready_i),
		.hreadyout_o (hreadyout_o),
		.rd_stb_o    (rd_stb),
		.wr_stb_o    (wr_stb),
		.wr_ofs_o    (wr_ofs)
	);

	// ----------------------------------------------------------------
	// Event decode
	// ----------------------------------------------------------------
	// Error pulses are folded into field positions once, used twice
	always_comb begin
		mode    = ctrl_q[CTRL_MODE_LSB +: MODE_W];
		flag_ok = f_flag_ok(mode);
		code_ok = f_code_ok(mode);
		comm_ev = |port_i.err;
		code_ev = CODE_RST;
		code_ev[CODE_PAR_BIT] = port_i.err.parity;
		code_ev[CODE_FRM_BIT] = port_i.err.framing;
		code_ev[CODE_OVR_BIT] = port_i.err.overrun;
		code_ev[CODE_TMO_BIT] = port_i.err.timeout;
	end

	// ----------------------------------------------------------------
	// Restart sequencer
	// ----------------------------------------------------------------
	// One restart per write of 1; a level would retrigger endlessly
	always_comb begin
		rs_d    = rs_q;
		go      = 1'b0;
		rs_done = 1'b0;
		case (rs_q)
			RS_IDLE: begin
				if (req_q && mode != MODE_PERIPH_BUS) begin
					go   = 1'b1;
					rs_d = RS_WAIT;
				end
			end
			RS_WAIT: begin
				if (port_i.restart_done) begin
					rs_done = 1'b1;
					rs_d    = RS_IDLE;
				end
			end
			default: rs_d = RS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rs_q <= RS_IDLE;
		end else if (ce_i) begin
			rs_q <= rs_d;
		end
	end

	// ----------------------------------------------------------------
	// Flags and registers
	// ----------------------------------------------------------------
	// Hardware sets are applied last so they win over clears
	always_comb begin
		comm_err_d = comm_err_q;
		act_d      = ACT_RST;
		restart_d  = restart_q;
		req_d      = req_q && !go;
		code_d     = code_q;
		settings_d = settings_q;
		ctrl_d     = ctrl_q;
		irq_en_d   = irq_en_q;
		irq_stat_d = irq_stat_q;
		if (f_is_otl(mode) || f_is_link(mode)) begin
			act_d = port_i.unit_active;
		end
		if (rs_done && ctrl_q[CTRL_AUTO_BIT]) begin
			restart_d = 1'b0;
		end
		if (go) begin
			comm_err_d = 1'b0;
			if (ctrl_q[CTRL_CLR_BIT]) begin
				code_d = CODE_RST;
			end
		end
		if (port_i.settings_done) begin
			settings_d = 1'b0;
		end
		if (wr_stb) begin
			case (wr_ofs)
				OFS_RESTART: begin
					restart_d = hwdata_i[FLAG_BIT];
					if (hwdata_i[FLAG_BIT] && mode != MODE_PERIPH_BUS) begin
						req_d = 1'b1;
					end
				end
				OFS_ERRCODE:  code_d     = hwdata_i[CODE_W-1:0];
				OFS_SETTINGS: settings_d = hwdata_i[FLAG_BIT];
				OFS_CTRL:     ctrl_d     = hwdata_i[CTRL_W-1:0];
				OFS_IRQ_CLR:  irq_stat_d = irq_stat_q & ~hwdata_i[IRQ_W-1:0];
				OFS_IRQ_EN:   irq_en_d   = hwdata_i[IRQ_W-1:0];
				default: ;
			endcase
		end
		if (comm_ev && flag_ok) begin
			comm_err_d = 1'b1;
		end
		if (code_ok) begin
			code_d = code_d | code_ev;
		end
		if (port_i.setup_instr) begin
			settings_d = 1'b1;
		end
		irq_ev = IRQ_RST;
		irq_ev[IRQ_COMM_BIT] = comm_ev && flag_ok;
		irq_ev[IRQ_CODE_BIT] = code_ok && (|code_ev);
		irq_ev[IRQ_SETD_BIT] = port_i.settings_done;
		irq_ev[IRQ_RSTD_BIT] = rs_done;
		irq_stat_d = irq_stat_d | irq_ev;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			comm_err_q <= 1'b0;
			act_q      <= ACT_RST;
			restart_q  <= 1'b0;
			req_q      <= 1'b0;
			code_q     <= CODE_RST;
			settings_q <= 1'b0;
			ctrl_q     <= CTRL_RST;
			irq_stat_q <= IRQ_RST;
			irq_en_q   <= IRQ_RST;
		end else if (ce_i) begin
			comm_err_q <= comm_err_d;
			act_q      <= act_d;
			restart_q  <= restart_d;
			req_q      <= req_d;
			code_q     <= code_d;
			settings_q <= settings_d;
			ctrl_q     <= ctrl_d;
			irq_stat_q <= irq_stat_d;
			irq_en_q   <= irq_en_d;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Sampled in the address phase so hrdata comes from a flop
	always_comb begin
		rd_ofs   = haddr_i[OFS_W-1:0];
		hrdata_d = hrdata_q;
		if (rd_stb) begin
			hrdata_d = RD_ZERO;
			case (rd_ofs)
				OFS_STATUS: begin
					hrdata_d[STAT_ERR_BIT] = comm_err_q;
					hrdata_d[STAT_ACT_LSB +: UNIT_N] = act_q;
				end
				OFS_RESTART:  hrdata_d[FLAG_BIT]     = restart_q;
				OFS_ERRCODE:  hrdata_d[CODE_W-1:0]   = code_q;
				OFS_SETTINGS: hrdata_d[FLAG_BIT]     = settings_q;
				OFS_CTRL:     hrdata_d[CTRL_W-1:0]   = ctrl_q;
				OFS_IRQ_STAT: hrdata_d[IRQ_W-1:0]    = irq_stat_q;
				OFS_IRQ_EN:   hrdata_d[IRQ_W-1:0]    = irq_en_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hrdata_q <= RD_ZERO;
		end else if (ce_i) begin
			hrdata_q <= hrdata_d;
		end
	end

	// Outputs; the response is always OKAY
	assign hresp_o   = 1'b0;
	assign hrdata_o  = hrdata_q;
	assign mode_o    = mode;
	assign irq_o     = |(irq_stat_q & irq_en_q);
	assign port_o.restart       = go;
	assign port_o.settings_busy = settings_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_restart_write;
		ce_i && wr_stb && wr_ofs == OFS_RESTART && hwdata_i[FLAG_BIT]
			&& mode != MODE_PERIPH_BUS && rs_q == RS_IDLE;
	endsequence

	sequence s_restart_issue;
		ce_i ##0 port_o.restart ##1 rs_q == RS_WAIT;
	endsequence

	chk_err_flag_set: assert property (
		ce_i && comm_ev && flag_ok |=> comm_err_q)
		else $error("error flag not set on error");
	chk_err_flag_clear: assert property (
		ce_i && go && !comm_ev |=> !comm_err_q)
		else $error("error flag not cleared by restart");
	chk_err_flag_frozen: assert property (
		ce_i && !flag_ok && !go |=> $stable(comm_err_q))
		else $error("error flag moved in a frozen mode");
	chk_reset_all_zero: assert property (
		@(posedge clk_i) disable iff (1'b0) reset_i |=> !comm_err_q && !restart_q
			&& !settings_q && code_q == CODE_RST && act_q == ACT_RST)
		else $error("flags not zero after reset");
	chk_unit_activity: assert property (
		ce_i && (f_is_otl(mode) || f_is_link(mode)) |=> act_q == $past(port_i.unit_active))
		else $error("activity bits do not follow units");
	chk_restart_start: assert property (
		s_restart_write ##1 ce_i[*2] |-> ##1 $past(port_o.restart) || rs_q == RS_WAIT)
		else $error("restart write did not start a restart");
	chk_restart_mode: assert property (
		port_o.restart |-> mode != MODE_PERIPH_BUS ##0 s_restart_issue or !ce_i)
		else $error("restart issued in peripheral bus mode");
	chk_restart_autoclr: assert property (
		ce_i && rs_done && ctrl_q[CTRL_AUTO_BIT] && !wr_stb |=> !restart_q)
		else $error("restart bit not cleared after done");
	chk_code_record: assert property (
		ce_i && code_ok && port_i.err.overrun |=> code_q[CODE_OVR_BIT])
		else $error("overrun not recorded at its bit");
	chk_code_restart_clr: assert property (
		ce_i && go && ctrl_q[CTRL_CLR_BIT] && !(|port_i.err) |=> code_q == CODE_RST)
		else $error("error field not cleared by restart");
	chk_code_frozen: assert property (
		ce_i && !code_ok && !go && !wr_stb |=> $stable(code_q))
		else $error("error field moved in a frozen mode");
	chk_settings_busy: assert property (
		ce_i && settings_q && !port_i.settings_done && !wr_stb |=> settings_q)
		else $error("settings flag dropped before done");
	chk_settings_set: assert property (
		ce_i && port_i.setup_instr |=> settings_q && port_o.settings_busy)
		else $error("setup instruction did not set flag");

endmodule

// ==== ssf_port_model.sv ====
/*
 * Far-side model of the serial port engine: unit activity levels, error,
 * setup and settings-done pulses on request, and restart completion after
 * a delay the bench chooses. Assumes the block's clock and reset.
 */
`timescale 1ns/1ps
module ssf_port_model
	import ssf_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      reset_i,
	input  wire ssf_pkg::ssf_port_out_type dut_out_i,
	output ssf_pkg::ssf_port_in_type       port_in_o
);
	ssf_err_ev_type    err_q     = '0;
	logic [UNIT_N-1:0] act_q     = '0;
	logic              setup_q   = 1'b0;
	logic              sdone_q   = 1'b0;
	logic              rdone_q   = 1'b0;
	int                done_dly  = 3;
	int                dly_cnt   = 0;
	int                n_restart = 0;
	int                n_done    = 0;

	// Activity is a level per unit; the rest are one-cycle pulses
	assign port_in_o = {err_q, act_q, setup_q, sdone_q, rdone_q};

	// Restart handshake, prompt or slow as done_dly says
	always @(posedge clk_i) begin
		rdone_q <= 1'b0;
		if (reset_i) begin
			dly_cnt <= 0;
		end else if (dut_out_i.restart === 1'b1) begin
			n_restart <= n_restart + 1;
			dly_cnt   <= done_dly;
		end else if (dly_cnt == 1) begin
			rdone_q <= 1'b1;
			n_done  <= n_done + 1;
			dly_cnt <= 0;
		end else if (dly_cnt > 1) begin
			dly_cnt <= dly_cnt - 1;
		end
	end

	// One-cycle event pulse, launched just after an edge
	task automatic pulse_ev(input ssf_err_ev_type e, input logic s, input logic d);
		@(posedge clk_i);
		err_q   <= e;
		setup_q <= s;
		sdone_q <= d;
		@(posedge clk_i);
		err_q   <= '0;
		setup_q <= 1'b0;
		sdone_q <= 1'b0;
	endtask
endmodule

// ==== testbench.sv ====
/*
 * Self-checking bench for the serial port flag block: AHB-Lite master
 * tasks, a pass over every operating mode with random events, restart
 * and settings handshakes. Assumes ssf_pkg, ssf_top, ssf_port_model.
 */
`timescale 1ns/1ps
module testbench;
	import ssf_pkg::*;
	logic              clk_i     = 1'b0;
	logic              reset_i   = 1'b1;
	logic              ce_i      = 1'b1;
	logic              hsel      = 1'b0;
	logic [ADDR_W-1:0] haddr     = '0;
	logic [1:0]        htrans    = 2'h0;
	logic              hwrite    = 1'b0;
	logic [DATA_W-1:0] hwdata    = '0;
	logic              hready;
	logic              hresp;
	logic [DATA_W-1:0] hrdata;
	ssf_port_in_type   port_in;
	ssf_port_out_type  port_out;
	logic [MODE_W-1:0] mode;
	logic              irq;
	int                n_errors  = 0;
	int                cmp_count = 0;
	integer            seed      = 32'hE8AF5219;

	always #2.5 clk_i = ~clk_i;

	ssf_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
		.hrdata_o(hrdata), .port_i(port_in), .port_o(port_out), .mode_o(mode), .irq_o(irq));
	ssf_port_model i_model (.clk_i(clk_i), .reset_i(reset_i), .dut_out_i(port_out),
		.port_in_o(port_in));

	// ------------------------------------------------------------
	// Compare, bus and expectation helpers
	// ------------------------------------------------------------
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask

	// One single transfer; holds each phase until hready is seen high
	task automatic ahb(input logic w, input logic [OFS_W-1:0] ofs, input logic [31:0] wd,
		output logic [31:0] rdat);
		@(posedge clk_i);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, ofs};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge clk_i);
		while (hready !== 1'b1)
			@(posedge clk_i);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk_i);
		while (hready !== 1'b1)
			@(posedge clk_i);
		rdat = hrdata;
	endtask

	task automatic wr(input logic [OFS_W-1:0] ofs, input logic [31:0] wd);
		logic [31:0] dummy;
		ahb(1'b1, ofs, wd, dummy);
	endtask

	task automatic rd_chk(input string what, input logic [OFS_W-1:0] ofs, input logic [31:0] exp);
		logic [31:0] got;
		ahb(1'b0, ofs, 32'h00000000, got);
		chk_word(what, exp, got);
		chk_bit("hresp", 1'b0, hresp);
	endtask

	// Which modes let each flag move
	function automatic logic want_flag(input logic [3:0] m);
		return !(m inside {4'h1, 4'h2, 4'h3, 4'h7, 4'h8});
	endfunction

	function automatic logic want_code(input logic [3:0] m);
		return !(m inside {4'h1, 4'h3, 4'h7, 4'h8});
	endfunction

	function automatic logic want_act(input logic [3:0] m);
		return m inside {4'h2, 4'h3, 4'h7, 4'h8};
	endfunction

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Whole run is near 500 cycles; forty times that means a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		end_of_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [3:0]       modes [7];
		logic [OFS_W-1:0] ofs_t [7];
		logic [31:0]      msk_t [7];
		logic [31:0]      rv;
		ssf_err_ev_type   ev;
		logic [7:0]       act;
		logic [3:0]       m;
		logic [3:0]       en;
		logic [3:0]       st;
		logic             auto;
		int               r0;
		int               d0;
		modes = '{4'h0, 4'h5, 4'h2, 4'h3, 4'h7, 4'h8, 4'h1};
		ofs_t = '{OFS_STATUS, OFS_ERRCODE, OFS_SETTINGS, OFS_CTRL, OFS_IRQ_STAT, OFS_IRQ_EN, 8'h20};
		msk_t = '{32'h0, 32'hFF, 32'h1, 32'h3F, 32'h0, 32'hF, 32'h0};
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		// Reset values, then access kinds with an unmapped word
		for (int a = 0; a < 9; a++)
			rd_chk("reset value", 8'(a * 4), RD_ZERO);
		for (int k = 0; k < 7; k++) begin
			rv = $random(seed);
			wr(ofs_t[k], rv);
			rd_chk("access", ofs_t[k], rv & msk_t[k]);
			wr(ofs_t[k], RD_ZERO);
		end
		$display("test reset and access done");
		// Mode 1 goes last: a refused restart sets no request, only the restart bit
		foreach (modes[i]) begin
			m = modes[i];
			auto = i[0];
			en = 4'($random(seed));
			ev = 4'($random(seed)) | 4'h1;
			act = 8'($random(seed));
			i_model.done_dly = 1 + ({$random(seed)} % 12);
			wr(OFS_CTRL, {26'h0, 1'b1, auto, m});
			@(negedge clk_i);
			chk_word("mode", {28'h0, m}, {28'h0, mode});
			wr(OFS_IRQ_EN, {28'h0, en});
			i_model.act_q <= act;
			i_model.pulse_ev(ev, 1'b0, 1'b0);
			rv = {16'h0, want_act(m) ? act : 8'h00, 7'h0, want_flag(m)};
			rd_chk("status", OFS_STATUS, rv);
			rd_chk("errcode", OFS_ERRCODE, want_code(m) ? {26'h0, ev, 2'h0} : RD_ZERO);
			r0 = i_model.n_restart;
			d0 = i_model.n_done;
			wr(OFS_RESTART, 32'h1);
			for (int k = 0; k < 20 && i_model.n_done == d0; k++)
				@(posedge clk_i);
			chk_word("restarts", r0 + (m != 4'h1), i_model.n_restart);
			rd_chk("flag after restart", OFS_STATUS, rv & 32'hFFFFFFFE);
			rd_chk("code after restart", OFS_ERRCODE, RD_ZERO);
			rd_chk("restart bit", OFS_RESTART, {31'h0, m == 4'h1 || !auto});
			st = {m != 4'h1, 1'b0, want_code(m), want_flag(m)};
			rd_chk("irq status", OFS_IRQ_STAT, {28'h0, st});
			@(negedge clk_i);
			chk_bit("irq", |(st & en), irq);
			wr(OFS_IRQ_CLR, 32'hF);
			rd_chk("irq cleared", OFS_IRQ_STAT, RD_ZERO);
			chk_bit("irq low", 1'b0, irq);
			wr(OFS_RESTART, RD_ZERO);
			$display("test mode %h done", m);
		end
		// Settings change handshake
		i_model.pulse_ev('0, 1'b1, 1'b0);
		@(negedge clk_i);
		chk_bit("settings busy", 1'b1, port_out.settings_busy);
		rd_chk("settings set", OFS_SETTINGS, 32'h1);
		// Clock enable low: a done pulse is missed and the bus stalls
		ce_i <= 1'b0;
		i_model.pulse_ev('0, 1'b0, 1'b1);
		@(negedge clk_i);
		chk_bit("hready frozen", 1'b0, hready);
		chk_bit("busy frozen", 1'b1, port_out.settings_busy);
		@(posedge clk_i);
		ce_i <= 1'b1;
		rd_chk("settings held", OFS_SETTINGS, 32'h1);
		i_model.pulse_ev('0, 1'b0, 1'b1);
		@(negedge clk_i);
		chk_bit("settings idle", 1'b0, port_out.settings_busy);
		rd_chk("settings clear", OFS_SETTINGS, RD_ZERO);
		rd_chk("settings irq", OFS_IRQ_STAT, 32'h4);
		$display("test settings done");
		end_of_test();
	end
endmodule
